// ---- inc/tlp_map.vh ----
// tlp_map.vh: register map, status layout, reset values and the display
// and touch-cell geometry of the parallel host port.
// assumes inclusion by bare name from the rtl files.
`ifndef TLP_MAP_VH
`define TLP_MAP_VH

// ----------------------------------------------------------------------
// register addresses (two address pins)
// ----------------------------------------------------------------------
`define TLP_ADDR_INSTRUCTION 2'h0
`define TLP_ADDR_RESULT 2'h0
`define TLP_ADDR_OPERAND 2'h1
`define TLP_ADDR_STATUS 2'h3

// ----------------------------------------------------------------------
// status register bit positions
// ----------------------------------------------------------------------
`define TLP_STAT_IBF 0
`define TLP_STAT_OBF_N 1
`define TLP_STAT_ERR 2
`define TLP_STAT_KEY 3
`define TLP_STAT_BUSY 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TLP_RST_BYTE 8'h00
`define TLP_RST_PINS 13'h1c00
`define TLP_RST_OBF_N 1'b1

// ----------------------------------------------------------------------
// display and touch geometry
// ----------------------------------------------------------------------
`define TLP_DISP_W 9'h0f0
`define TLP_DISP_H 8'h80
`define TLP_CELL_COLS 4'ha
`define TLP_CELL_ROWS 3'h6
`define TLP_CELL_W 8'h14
`define TLP_CELL_H 7'h12
`define TLP_GAP_X 8'h04
`define TLP_GAP_Y 7'h03

`endif

// ---- rtl/tlp_sync.v ----
// tlp_sync.v: three-stage synchroniser for a group of pin inputs.
// assumes pins are asynchronous to ref_clk; output changes only once
// the second and third stages agree.
`timescale 1ns/1ps

module tlp_sync #(
    parameter W = 13,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // pins in, filtered levels out
    input wire [W-1:0] pin_in,
    output wire [W-1:0] pin_out
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;
            // first stage feeds only the second
            always @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_q <= RST_VAL[i];
                    s2_q <= RST_VAL[i];
                    s3_q <= RST_VAL[i];
                    out_q <= RST_VAL[i];
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        out_q <= s3_q;
                    end
                end
            end
            assign pin_out[i] = out_q;
        end
    endgenerate

endmodule

// ---- rtl/tlp_port.v ----
// tlp_port.v: host parallel command port of the touch display controller.
// assumes an asynchronous host on the pins and the controller core on
// ref_clk behind the core-side ports.
//
// Operation
// - eight-bit data bus, two address lines, strobes
// - address 0 write starts a new instruction
// - address 1 writes route operands to instruction
// - string operands end at next instruction write
// - new instruction abandons one awaiting operands
// - result bytes read at address 0
// - status readable at address 3 any time
// - select high ignored; write decode per address
// - read decode: 0 result, 3 status
// - display 240 by 128, origin upper left
// - touch cells 10 by 6, origin upper left
// - each cell 20 wide, 18 high
// - gaps of 4 and 3 pixels between cells
// - input buffer full flag, one deep
// - output flag low while result waits
// - status bit layout, upper bits zero
// - busy set on instruction, cleared when done
`timescale 1ns/1ps
`include "tlp_map.vh"

module tlp_port (
    // clock and reset
    input wire ref_clk,
    input wire sys_rst,
    // host pins
    input wire module_select_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire reg_addr_bit_low,
    input wire reg_addr_bit_high,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    output reg input_buffer_full,
    output reg output_ready_n,
    output reg error_flag,
    output reg touch_button_event,
    // byte handed to the core
    output reg cmd_valid,
    output reg [7:0] cmd_byte,
    output reg cmd_is_opcode,
    output reg cmd_abort,
    input wire cmd_take,
    input wire core_wait_operand,
    // core results and events
    input wire result_valid,
    input wire [7:0] result_byte,
    input wire core_done,
    input wire core_error,
    input wire core_key_event,
    output reg command_executing,
    // geometry helpers
    input wire [3:0] cell_col,
    input wire [2:0] cell_row,
    output reg [7:0] cell_px_x,
    output reg [6:0] cell_px_y,
    output reg cell_ok,
    input wire [8:0] px_x,
    input wire [7:0] px_y,
    output reg px_ok
);

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    wire [12:0] pin_s;

    tlp_sync #(
        .W(13),
        .RST_VAL(`TLP_RST_PINS)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_in({module_select_n, read_strobe_n, write_strobe_n,
                 reg_addr_bit_high, reg_addr_bit_low, data_in}),
        .pin_out(pin_s)
    );

    wire sel_n_s = pin_s[12];
    wire rd_n_s = pin_s[11];
    wire wr_n_s = pin_s[10];
    wire [1:0] addr_s = pin_s[9:8];
    wire [7:0] data_s = pin_s[7:0];

    // both strobes low is undefined and does nothing
    wire wr_act = ~sel_n_s & ~wr_n_s & rd_n_s;
    wire rd_act = ~sel_n_s & ~rd_n_s & wr_n_s;

    // ------------------------------------------------------------------
    // strobe tracking
    // ------------------------------------------------------------------
    reg wr_act_q;
    reg rd_act_q;
    reg [1:0] waddr_q;
    reg [7:0] wdata_q;
    reg [1:0] raddr_q;

    // commit at the trailing edge so data has settled through the sync
    wire wr_end = wr_act_q & ~wr_act;
    wire rd_end = rd_act_q & ~rd_act;
    wire wr_op = wr_end & (waddr_q == `TLP_ADDR_INSTRUCTION);
    wire wr_dat = wr_end & (waddr_q == `TLP_ADDR_OPERAND);
    wire rd_res = rd_end & (raddr_q == `TLP_ADDR_RESULT);

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
            waddr_q <= 2'h0;
            wdata_q <= `TLP_RST_BYTE;
            raddr_q <= 2'h0;
        end else begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
            if (wr_act) begin
                waddr_q <= addr_s;
                wdata_q <= data_s;
            end
            if (rd_act) begin
                raddr_q <= addr_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // input buffer towards the core
    // ------------------------------------------------------------------
    reg ibf_d;
    reg cmd_abort_d;

    always @* begin
        ibf_d = input_buffer_full;
        cmd_abort_d = 1'b0;
        if (cmd_take) begin
            ibf_d = 1'b0;
        end
        // a write while full is the host's fault and is dropped
        if ((wr_op | wr_dat) & ~input_buffer_full) begin
            ibf_d = 1'b1;
        end
        // opcode ends a string or abandons a half-fed instruction
        if (wr_op & ~input_buffer_full & core_wait_operand) begin
            cmd_abort_d = 1'b1;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            input_buffer_full <= 1'b0;
            cmd_valid <= 1'b0;
            cmd_byte <= `TLP_RST_BYTE;
            cmd_is_opcode <= 1'b0;
            cmd_abort <= 1'b0;
        end else begin
            input_buffer_full <= ibf_d;
            cmd_valid <= ibf_d;
            cmd_abort <= cmd_abort_d;
            if ((wr_op | wr_dat) & ~input_buffer_full) begin
                cmd_byte <= wdata_q;
                cmd_is_opcode <= wr_op;
            end
        end
    end

    // ------------------------------------------------------------------
    // result register and flags
    // ------------------------------------------------------------------
    reg [7:0] result_q;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_q <= `TLP_RST_BYTE;
            output_ready_n <= `TLP_RST_OBF_N;
            error_flag <= 1'b0;
            touch_button_event <= 1'b0;
            command_executing <= 1'b0;
        end else begin
            // a new result beats the read that clears the old one
            if (result_valid) begin
                result_q <= result_byte;
                output_ready_n <= 1'b0;
            end else if (rd_res) begin
                output_ready_n <= 1'b1;
            end
            // error holds until the next instruction write is accepted into the buffer
            if (core_error) begin
                error_flag <= 1'b1;
            end else if (wr_op & ~input_buffer_full) begin
                error_flag <= 1'b0;
            end
            // button code is fetched as a result byte
            if (core_key_event) begin
                touch_button_event <= 1'b1;
            end else if (rd_res) begin
                touch_button_event <= 1'b0;
            end
            if (wr_op & ~input_buffer_full) begin
                command_executing <= 1'b1;
            end else if (core_done) begin
                command_executing <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    reg [7:0] status_d;
    reg [7:0] dout_d;
    reg oe_n_d;

    always @* begin
        status_d = 8'h00;
        status_d[`TLP_STAT_IBF] = input_buffer_full;
        status_d[`TLP_STAT_OBF_N] = output_ready_n;
        status_d[`TLP_STAT_ERR] = error_flag;
        status_d[`TLP_STAT_KEY] = touch_button_event;
        status_d[`TLP_STAT_BUSY] = command_executing;
        dout_d = data_out;
        oe_n_d = 1'b1;
        if (rd_act && addr_s == `TLP_ADDR_RESULT) begin
            dout_d = result_q;
            oe_n_d = 1'b0;
        end else if (rd_act && addr_s == `TLP_ADDR_STATUS) begin
            // status reads leave every flag untouched
            dout_d = status_d;
            oe_n_d = 1'b0;
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out <= `TLP_RST_BYTE;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= dout_d;
            data_oe_n <= oe_n_d;
        end
    end

    // ------------------------------------------------------------------
    // display and touch geometry
    // ------------------------------------------------------------------
    wire [7:0] pitch_x = `TLP_CELL_W + `TLP_GAP_X;
    wire [6:0] pitch_y = `TLP_CELL_H + `TLP_GAP_Y;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cell_px_x <= 8'h00;
            cell_px_y <= 7'h00;
            cell_ok <= 1'b0;
            px_ok <= 1'b0;
        end else begin
            // cell origin in pixels, upper left first
            cell_px_x <= {4'h0, cell_col} * pitch_x;
            cell_px_y <= {4'h0, cell_row} * pitch_y;
            cell_ok <= (cell_col < `TLP_CELL_COLS) &&
                       (cell_row < `TLP_CELL_ROWS);
            px_ok <= (px_x < `TLP_DISP_W) &&
                     (px_y < `TLP_DISP_H);
        end
    end

endmodule

// ---- tb/tlp_port_monitor.sv ----
// tlp_port_monitor.sv: assertions on the parallel port pins and core side.
// assumes bound into tlp_port; one clock, async active-high reset.
`timescale 1ns/1ps

module tlp_port_monitor (
    // clock and reset
    input logic ref_clk,
    input logic sys_rst,
    // host pins
    input logic module_select_n,
    input logic read_strobe_n,
    input logic reg_addr_bit_low,
    input logic reg_addr_bit_high,
    input logic data_oe_n,
    input logic input_buffer_full,
    input logic output_ready_n,
    // core side
    input logic cmd_valid,
    input logic cmd_take,
    input logic cmd_is_opcode,
    input logic cmd_abort,
    input logic result_valid,
    input logic core_done,
    input logic command_executing,
    // geometry
    input logic [3:0] cell_col,
    input logic [2:0] cell_row,
    input logic [7:0] cell_px_x,
    input logic [6:0] cell_px_y,
    input logic cell_ok,
    input logic [8:0] px_x,
    input logic [7:0] px_y,
    input logic px_ok
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    ibf_pair_a: assert property (cmd_valid == input_buffer_full)
        else $error("byte valid differs from buffer flag");
    ibf_clear_a: assert property ($fell(input_buffer_full) |->
        $past(cmd_take))
        else $error("buffer flag dropped without a take");
    abort_pulse_a: assert property (cmd_abort |->
        cmd_is_opcode && input_buffer_full ##1 !cmd_abort)
        else $error("abort not a single opcode pulse");
    busy_set_a: assert property ($rose(input_buffer_full) &&
        cmd_is_opcode |-> command_executing)
        else $error("busy not set by opcode");
    busy_clear_a: assert property (core_done |=>
        !command_executing || (input_buffer_full && cmd_is_opcode))
        else $error("busy not cleared by done");
    result_wait_a: assert property (result_valid |=> !output_ready_n)
        else $error("output flag not low after result");
    cell_pitch_a: assert property (!$past(sys_rst) &&
        cell_col < 4'ha && cell_row < 3'h6 |=>
        cell_px_x == $past(cell_col) * 8'd24 &&
        cell_px_y == $past(cell_row) * 7'd21)
        else $error("cell pixel origin wrong");
    range_ok_a: assert property (!$past(sys_rst) |=>
        cell_ok == ($past(cell_col) < 4'ha && $past(cell_row) < 3'h6) &&
        px_ok == ($past(px_x) < 9'h0f0 && $past(px_y) < 8'h80))
        else $error("range flag wrong");
    read_drive_a: assert property ($fell(data_oe_n) |->
        !$past(read_strobe_n, 2) && !$past(module_select_n, 2) &&
        $past(reg_addr_bit_low, 2) == $past(reg_addr_bit_high, 2))
        else $error("bus driven without legal read");

    cover property (cmd_abort);
    cover property ($fell(data_oe_n));
    cover property (core_done ##1 !command_executing);
endmodule

// ---- tb/tlp_host_model.sv ----
// tlp_host_model.sv: host processor on the eight-bit parallel bus.
// assumes tasks are called from the bench; pins move at falling edges.
`timescale 1ns/1ps

module tlp_host_model (
    // clock and handshake
    input wire ref_clk,
    input wire input_buffer_full,
    // host pins
    output reg module_select_n = 1'b1,
    output reg read_strobe_n = 1'b1,
    output reg write_strobe_n = 1'b1,
    output reg reg_addr_bit_low = 1'b0,
    output reg reg_addr_bit_high = 1'b0,
    output reg [7:0] data_in = 8'h00
);
    // one access; len sets strobe width so slow hosts are covered too
    task cycle(input sel_n, input rd, input [1:0] a, input [7:0] d,
            input integer len, input wait_ibf);
        integer n;
        begin
            n = 0;
            while (wait_ibf && input_buffer_full && n < 400) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            @(negedge ref_clk);
            module_select_n = sel_n;
            {reg_addr_bit_high, reg_addr_bit_low} = a;
            if (!rd)
                data_in = d;
            read_strobe_n = !rd;
            write_strobe_n = rd;
            repeat (len) @(negedge ref_clk);
            read_strobe_n = 1'b1;
            write_strobe_n = 1'b1;
            module_select_n = 1'b1;
            // pins pass a synchroniser, so data must outlive the strobe
            repeat (6) @(negedge ref_clk);
            data_in = ~data_in;
            repeat (6) @(negedge ref_clk);
        end
    endtask
endmodule

// ---- tb/tlp_port_tb.sv ----
// tlp_port_tb.sv: self-checking bench for the parallel host port.
// assumes tlp_port, its include file and the host model are compiled.
`timescale 1ns/1ps

module tlp_port_tb;
    // ----
    // wiring
    // ----
    logic ref_clk = 1'b0, sys_rst = 1'b1;
    logic module_select_n, read_strobe_n, write_strobe_n;
    logic reg_addr_bit_low, reg_addr_bit_high, data_oe_n, input_buffer_full;
    logic output_ready_n, error_flag, touch_button_event, cmd_valid;
    logic cmd_is_opcode, cmd_abort, command_executing, cell_ok, px_ok;
    logic [7:0] data_in, data_out, cmd_byte, cell_px_x, px_y = 8'h00;
    logic [6:0] cell_px_y;
    logic cmd_take = 1'b0, core_wait_operand = 1'b0, result_valid = 1'b0;
    logic core_done = 1'b0, core_error = 1'b0, core_key_event = 1'b0;
    logic [7:0] result_byte = 8'h00;
    logic [3:0] cell_col = 4'h0;
    logic [2:0] cell_row = 3'h0;
    logic [8:0] px_x = 9'h000;
    logic hold_take = 1'b0, ibf_q = 1'b0, oe_q = 1'b1;
    integer failures = 0, tests_run = 0, cyc = 0, seed = 32'h71d96c39, i;
    logic [9:0] wq[$];
    logic [7:0] rq[$];

    tlp_port tlp_port_i (.ref_clk, .sys_rst, .module_select_n,
        .read_strobe_n, .write_strobe_n, .reg_addr_bit_low,
        .reg_addr_bit_high, .data_in, .data_out, .data_oe_n,
        .input_buffer_full, .output_ready_n, .error_flag,
        .touch_button_event, .cmd_valid, .cmd_byte, .cmd_is_opcode,
        .cmd_abort, .cmd_take, .core_wait_operand, .result_valid,
        .result_byte, .core_done, .core_error, .core_key_event,
        .command_executing, .cell_col, .cell_row, .cell_px_x, .cell_px_y,
        .cell_ok, .px_x, .px_y, .px_ok);
    tlp_host_model tlp_host_model_i (.ref_clk, .input_buffer_full,
        .module_select_n, .read_strobe_n, .write_strobe_n,
        .reg_addr_bit_low, .reg_addr_bit_high, .data_in);

    always #2.5 ref_clk = ~ref_clk;

    // ----
    // checking
    // ----
    task fail(input [9:0] got, input [9:0] exp);
        begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cmp_w(input [9:0] got);
        begin
            tests_run = tests_run + 1;
            if (wq.size() == 0)
                fail(got, ~got);
            else if (got !== wq[0])
                fail(got, wq[0]);
            if (wq.size() != 0)
                void'(wq.pop_front());
        end
    endtask
    task cmp_r(input [7:0] got);
        begin
            tests_run = tests_run + 1;
            if (rq.size() == 0)
                fail(got, ~got);
            else if (got !== rq[0])
                fail(got, rq[0]);
            if (rq.size() != 0)
                void'(rq.pop_front());
        end
    endtask
    task print_verdict;
        begin
            if (wq.size() + rq.size() != 0)
                fail(wq.size(), rq.size());
            if (failures == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // core stand-in, random geometry and watchdog
    always @(negedge ref_clk) begin
        cmd_take <= input_buffer_full && !cmd_take && !hold_take;
        {cell_col, cell_row, px_x, px_y} <= 24'($random(seed));
        ibf_q <= input_buffer_full;
        oe_q <= data_oe_n;
        if (input_buffer_full === 1'b1 && ibf_q === 1'b0)
            cmp_w({cmd_abort, cmd_is_opcode, cmd_byte});
        if (data_oe_n === 1'b0 && oe_q === 1'b1)
            cmp_r(data_out);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail(10'h000, 10'h3ff);
            print_verdict();
        end
    end

    // ----
    // stimulus
    // ----
    task put(input [1:0] a, input [7:0] d, input ab);
        begin
            if (a < 2'h2)
                wq.push_back({ab, a == 2'h0, d});
            tlp_host_model_i.cycle(1'b0, 1'b0, a, d, 6 + ($random(seed) & 3),
                1'b1);
        end
    endtask
    task get(input [1:0] a, input [7:0] e);
        begin
            if (a == 2'h0 || a == 2'h3)
                rq.push_back(e);
            tlp_host_model_i.cycle(1'b0, 1'b1, a, 8'h00,
                6 + ($random(seed) & 3), 1'b0);
        end
    endtask

    initial begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        get(2'h3, 8'h02);
        put(2'h0, 8'h5a, 1'b0);
        get(2'h3, 8'h12);
        core_wait_operand = 1'b1;
        for (i = 0; i < 3; i = i + 1)
            put(2'h1, 8'($random(seed)), 1'b0);
        put(2'h0, 8'h81, 1'b1);
        core_wait_operand = 1'b0;
        tlp_host_model_i.cycle(1'b1, 1'b0, 2'h0, 8'h33, 6, 1'b1);
        put(2'h2, 8'h44, 1'b0);
        put(2'h3, 8'h55, 1'b0);
        get(2'h1, 8'h00);
        get(2'h2, 8'h00);
        hold_take <= 1'b1;
        put(2'h0, 8'h3c, 1'b0);
        tlp_host_model_i.cycle(1'b0, 1'b0, 2'h1, 8'h99, 6, 1'b0);
        get(2'h3, 8'h13);
        hold_take <= 1'b0;
        {result_valid, core_error, core_key_event, core_done} = 4'hf;
        result_byte = 8'hc7;
        @(negedge ref_clk);
        {result_valid, core_error, core_key_event, core_done} = 4'h0;
        get(2'h3, 8'h0c);
        get(2'h0, 8'hc7);
        get(2'h3, 8'h06);
        put(2'h0, 8'h11, 1'b0);
        get(2'h3, 8'h12);
        result_valid = 1'b1;
        @(negedge ref_clk);
        result_valid = 1'b0;
        get(2'h3, 8'h10);
        // mid-run reset must drop busy and the pending result flag
        sys_rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        get(2'h3, 8'h02);
        print_verdict();
    end
endmodule

bind tlp_port tlp_port_monitor tlp_port_monitor_i (.ref_clk, .sys_rst,
    .module_select_n, .read_strobe_n, .reg_addr_bit_low, .reg_addr_bit_high,
    .data_oe_n, .input_buffer_full, .output_ready_n, .cmd_valid, .cmd_take,
    .cmd_is_opcode, .cmd_abort, .result_valid, .core_done,
    .command_executing, .cell_col, .cell_row, .cell_px_x, .cell_px_y,
    .cell_ok, .px_x, .px_y, .px_ok);
